// >>> can_rx_pkg.sv
package can_rx_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] ADDR_PIN_CTRL = 8'h0c;
    localparam logic [7:0] ADDR_BUF0_CTRL = 8'h60;
    localparam logic [7:0] ADDR_BUF1_CTRL = 8'h70;
    localparam logic [7:0] REG_RESET = 8'h00;
    // ==========================================================
    // buffer control fields
    localparam int MODE_LO = 5;
    localparam int RTR_BIT = 3;
    localparam int ROLL_BIT = 2;
    localparam int MIRROR_BIT = 1;
    localparam int HIT0_BIT = 0;
    // ==========================================================
    // full pin control fields
    localparam int PIN_LEVEL_LO = 4;
    localparam int PIN_EN_LO = 2;
    localparam int PIN_SEL_LO = 0;
    // ==========================================================
    // receive modes
    typedef logic [1:0] rx_mode_t;
    localparam rx_mode_t MODE_FILTERED = 2'h0;
    localparam rx_mode_t MODE_ANY = 2'h3;
    // ==========================================================
    // status codes: a reset code and one per receive buffer
    localparam logic [3:0] STATUS_RESET = 4'h0;
    localparam logic [3:0] STATUS_BUF0 = 4'h1;
    localparam logic [3:0] STATUS_BUF1 = 4'h2;
    // ==========================================================
    // link timing, in link clock cycles
    typedef logic [6:0] tick_t;
    localparam tick_t BIT_TICKS = 7'h0a;
    localparam tick_t SAMPLE_TICKS = 7'h07;
    localparam tick_t IDLE_TICKS = 7'h6e;
    localparam tick_t TICK_ONE = 7'h01;
    localparam tick_t TICK_ZERO = 7'h00;
endpackage

// >>> full_pin_if.sv
`timescale 1ns/10ps
`default_nettype none
interface full_pin_if;
    logic [1:0] enable;
    logic [1:0] irq_select;
    logic [1:0] level;
    logic [1:0] loaded;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
    modport ctrl (output enable, output irq_select, output level, output loaded,
                  input pin_out, input pin_oe);
    modport pin (input enable, input irq_select, input level, input loaded,
                 output pin_out, output pin_oe);
endinterface
`default_nettype wire

// >>> full_pin_driver.sv
`timescale 1ns/10ps
`default_nettype none
module full_pin_driver (
    input wire logic clock_in,
    input wire logic rst_b_in,
    full_pin_if.pin pins
);
    // ==========================================================
    // one driver per buffer full pin
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_pin
            always_ff @(posedge clock_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    pins.pin_oe[g] <= 1'b0;
                    pins.pin_out[g] <= 1'b1;
                end else begin
                    pins.pin_oe[g] <= pins.enable[g];
                    if (pins.irq_select[g]) begin
                        pins.pin_out[g] <= ~pins.loaded[g];
                    end else begin
                        pins.pin_out[g] <= pins.level[g];
                    end
                end
            end
            a_pin_disabled: assert property (@(posedge clock_in) disable iff (!rst_b_in)
                !pins.enable[g] |=> !pins.pin_oe[g])
                else $error("full pin driven while disabled");
        end
    endgenerate
endmodule
`default_nettype wire

// >>> frame_start_detect.sv
`timescale 1ns/10ps
`default_nettype none
module frame_start_detect
    import can_rx_pkg::*;
(
    input wire logic link_clk_in,
    input wire logic rst_b_in,
    input wire logic bus_receive_line_in,
    output logic start_toggle_out
);
    typedef enum logic [2:0] {
        ST_WAIT_IDLE = 3'h1,
        ST_IDLE = 3'h2,
        ST_CHECK = 3'h4
    } sof_state_e;
    sof_state_e state_q;
    logic line_s1_q, line_s2_q;
    tick_t count_q;
    // ==========================================================
    // bus line synchroniser
    always_ff @(posedge link_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            line_s1_q <= 1'b1;
            line_s2_q <= 1'b1;
        end else begin
            line_s1_q <= bus_receive_line_in;
            line_s2_q <= line_s1_q;
        end
    end
    // ==========================================================
    // idle watch and glitch filter; the bus counts as idle after a run of recessive bits
    always_ff @(posedge link_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= ST_WAIT_IDLE;
            count_q <= TICK_ZERO;
            start_toggle_out <= 1'b0;
        end else begin
            unique case (state_q)
                ST_WAIT_IDLE: begin
                    if (!line_s2_q) begin
                        count_q <= TICK_ZERO;
                    end else if (count_q == IDLE_TICKS - TICK_ONE) begin
                        state_q <= ST_IDLE;
                    end else begin
                        count_q <= count_q + TICK_ONE;
                    end
                end
                ST_IDLE: begin
                    count_q <= TICK_ZERO;
                    if (!line_s2_q) begin
                        state_q <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    if (line_s2_q) begin
                        state_q <= ST_IDLE;
                    end else if (count_q == SAMPLE_TICKS - TICK_ONE) begin
                        start_toggle_out <= ~start_toggle_out;
                        count_q <= TICK_ZERO;
                        state_q <= ST_WAIT_IDLE;
                    end else begin
                        count_q <= count_q + TICK_ONE;
                    end
                end
            endcase
        end
    end
    a_glitch_rejected: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
        (state_q == ST_CHECK && line_s2_q) |=> $stable(start_toggle_out))
        else $error("frame start raised on a glitch");
endmodule
`default_nettype wire

// >>> can_rx_control.sv
`timescale 1ns/10ps
`default_nettype none
module can_rx_control
    import can_rx_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic link_clk_in,
    input wire logic bus_receive_line_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_wmask_in,
    output logic [7:0] reg_rdata_out,
    input wire logic sof_enable_in,
    output logic frame_start_out,
    output logic assemble_start_out,
    input wire logic msg_done_in,
    input wire logic msg_valid_in,
    input wire logic msg_rtr_in,
    input wire logic buf0_match_in,
    input wire logic buf0_filter_in,
    input wire logic buf1_match_in,
    input wire logic [2:0] buf1_filter_in,
    output logic store_buf0_out,
    output logic store_buf1_out,
    output logic error_frame_out,
    input wire logic [1:0] rx_flag_clear_in,
    input wire logic [1:0] overflow_clear_in,
    input wire logic [1:0] rx_loaded_irq_enable_in,
    input wire logic error_irq_enable_in,
    output logic [1:0] rx_loaded_flag_out,
    output logic [1:0] overflow_flag_out,
    output logic [3:0] status_code_out,
    output logic irq_b_out,
    output logic [1:0] data_byte_filter_out,
    output logic [1:0] buf_full_pin_out,
    output logic [1:0] buf_full_pin_oe_out
);
    import can_rx_pkg::*;

    function automatic logic accepts_all(input rx_mode_t mode);
        return mode == MODE_ANY;
    endfunction

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data,
                                         input logic [7:0] mask);
        return (old & ~mask) | (data & mask);
    endfunction

    // ==========================================================
    // register state
    rx_mode_t mode0_q, mode1_q;
    logic roll_q, rtr0_q, rtr1_q, hit0_q;
    logic [2:0] hit1_q;
    logic [1:0] pin_level_q, pin_en_q, pin_sel_q;
    logic [7:0] pin_ctrl_rd, buf0_rd, buf1_rd;
    logic [7:0] pin_ctrl_new, buf0_new;
    logic [7:0] buf1_new;

    // read values; the rollover mirror and filter hits are read only
    always_comb begin
        pin_ctrl_rd = REG_RESET;
        pin_ctrl_rd[PIN_LEVEL_LO +: 2] = pin_level_q & ~(pin_en_q & pin_sel_q);
        pin_ctrl_rd[PIN_EN_LO +: 2] = pin_en_q;
        pin_ctrl_rd[PIN_SEL_LO +: 2] = pin_sel_q;
        buf0_rd = REG_RESET;
        buf0_rd[MODE_LO +: 2] = mode0_q;
        buf0_rd[RTR_BIT] = rtr0_q;
        buf0_rd[ROLL_BIT] = roll_q;
        buf0_rd[MIRROR_BIT] = roll_q;
        buf0_rd[HIT0_BIT] = hit0_q;
        buf1_rd = REG_RESET;
        buf1_rd[MODE_LO +: 2] = mode1_q;
        buf1_rd[RTR_BIT] = rtr1_q;
        buf1_rd[HIT0_BIT +: 3] = hit1_q;
        pin_ctrl_new = merge({2'h0, pin_level_q, pin_en_q, pin_sel_q}, reg_wdata_in, reg_wmask_in);
        buf0_new = merge(buf0_rd, reg_wdata_in, reg_wmask_in);
        buf1_new = merge(buf1_rd, reg_wdata_in, reg_wmask_in);
    end

    // ==========================================================
    // register writes; a plain write carries an all-ones mask
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_level_q <= 2'h0;
            pin_en_q <= 2'h0;
            pin_sel_q <= 2'h0;
            mode0_q <= MODE_FILTERED;
            mode1_q <= MODE_FILTERED;
            roll_q <= 1'b0;
        end else if (reg_wr_in) begin
            unique case (reg_addr_in)
                ADDR_PIN_CTRL: begin
                    pin_level_q <= pin_ctrl_new[PIN_LEVEL_LO +: 2];
                    pin_en_q <= pin_ctrl_new[PIN_EN_LO +: 2];
                    pin_sel_q <= pin_ctrl_new[PIN_SEL_LO +: 2];
                end
                ADDR_BUF0_CTRL: begin
                    mode0_q <= buf0_new[MODE_LO +: 2];
                    roll_q <= buf0_new[ROLL_BIT];
                end
                ADDR_BUF1_CTRL: begin
                    mode1_q <= buf1_new[MODE_LO +: 2];
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // register reads, answered one cycle after the strobe
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= REG_RESET;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                ADDR_PIN_CTRL: reg_rdata_out <= pin_ctrl_rd;
                ADDR_BUF0_CTRL: reg_rdata_out <= buf0_rd;
                ADDR_BUF1_CTRL: reg_rdata_out <= buf1_rd;
                default: reg_rdata_out <= REG_RESET;
            endcase
        end
    end

    // ==========================================================
    // frame start from the link domain; toggle crossing keeps every start
    logic start_tgl, start_s1_q, start_s2_q, start_s3_q, start_evt;
    frame_start_detect u_sof (
        .link_clk_in(link_clk_in),
        .rst_b_in(rst_b_in),
        .bus_receive_line_in(bus_receive_line_in),
        .start_toggle_out(start_tgl)
    );
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            start_s1_q <= 1'b0;
            start_s2_q <= 1'b0;
            start_s3_q <= 1'b0;
        end else begin
            start_s1_q <= start_tgl;
            start_s2_q <= start_s1_q;
            start_s3_q <= start_s2_q;
        end
    end
    assign start_evt = start_s2_q ^ start_s3_q;
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            frame_start_out <= 1'b0;
            assemble_start_out <= 1'b0;
        end else begin
            frame_start_out <= start_evt && sof_enable_in;
            assemble_start_out <= start_evt;
        end
    end

    // ==========================================================
    // acceptance and buffer steering
    logic acc0, acc1, do_store0, do_store1, do_ovr0, do_ovr1, rolled;
    logic [2:0] hit1_d;
    logic [1:0] flag_q, ovr_q;
    always_comb begin
        acc0 = accepts_all(mode0_q) || (msg_valid_in && buf0_match_in);
        acc1 = accepts_all(mode1_q) || (msg_valid_in && buf1_match_in);
        do_store0 = 1'b0;
        do_store1 = 1'b0;
        do_ovr0 = 1'b0;
        do_ovr1 = 1'b0;
        rolled = 1'b0;
        hit1_d = buf1_filter_in;
        if (msg_done_in && acc0) begin
            if (!flag_q[0]) begin
                do_store0 = 1'b1;
            end else if (roll_q) begin
                rolled = 1'b1;
                hit1_d = {2'h0, buf0_filter_in};
                do_store1 = !flag_q[1];
                do_ovr1 = flag_q[1];
            end else begin
                do_ovr0 = 1'b1;
            end
        end else if (msg_done_in && acc1) begin
            do_store1 = !flag_q[1];
            do_ovr1 = flag_q[1];
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            store_buf0_out <= 1'b0;
            store_buf1_out <= 1'b0;
            error_frame_out <= 1'b0;
        end else begin
            store_buf0_out <= do_store0;
            store_buf1_out <= do_store1;
            error_frame_out <= msg_done_in && !msg_valid_in;
        end
    end

    // captured message attributes
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rtr0_q <= 1'b0;
            rtr1_q <= 1'b0;
            hit0_q <= 1'b0;
            hit1_q <= 3'h0;
        end else begin
            if (do_store0 || rolled) begin
                hit0_q <= buf0_filter_in;
            end
            if (do_store0) begin
                rtr0_q <= msg_rtr_in;
            end
            if (do_store1) begin
                rtr1_q <= msg_rtr_in;
                hit1_q <= hit1_d;
            end
        end
    end

    // ==========================================================
    // flags; a set in the same cycle as a clear wins
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flag_q <= 2'h0;
            ovr_q <= 2'h0;
            status_code_out <= STATUS_RESET;
        end else begin
            flag_q <= (flag_q & ~rx_flag_clear_in) | {do_store1, do_store0};
            ovr_q <= (ovr_q & ~overflow_clear_in) | {do_ovr1, do_ovr0};
            if (do_store0) begin
                status_code_out <= STATUS_BUF0;
            end else if (do_store1) begin
                status_code_out <= STATUS_BUF1;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_loaded_flag_out <= 2'h0;
            overflow_flag_out <= 2'h0;
            irq_b_out <= 1'b1;
            data_byte_filter_out <= 2'h0;
        end else begin
            rx_loaded_flag_out <= flag_q;
            overflow_flag_out <= ovr_q;
            irq_b_out <= !(|(flag_q & rx_loaded_irq_enable_in) ||
                           (error_irq_enable_in && |ovr_q));
            data_byte_filter_out <= {mode1_q == MODE_FILTERED,
                                     mode0_q == MODE_FILTERED};
        end
    end

    // ==========================================================
    // buffer full pins
    full_pin_if pins ();
    assign pins.enable = pin_en_q;
    assign pins.irq_select = pin_sel_q;
    assign pins.level = pin_level_q;
    assign pins.loaded = flag_q;
    assign buf_full_pin_out = pins.pin_out;
    assign buf_full_pin_oe_out = pins.pin_oe;
    full_pin_driver u_pins (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .pins(pins.pin)
    );

    // ==========================================================
    // checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    a_sof_gated: assert property (frame_start_out |-> $past(sof_enable_in))
        else $error("frame start pulse while disabled");
    a_sof_follows: assert property (start_evt && sof_enable_in |=> frame_start_out)
        else $error("frame start pulse missing");
    // pin flop lags the flags by one cycle, so hold the condition two cycles
    a_int_pin_low: assert property ((pin_en_q[0] && pin_sel_q[0] && flag_q[0]) [*2]
        |-> !buf_full_pin_out[0])
        else $error("interrupt full pin not low");
    a_gpo_level: assert property ((pin_en_q[1] && !pin_sel_q[1]) [*2]
        |-> buf_full_pin_out[1] == $past(pin_level_q[1]))
        else $error("output full pin level wrong");
    a_level_read: assert property (reg_rd_in && reg_addr_in == ADDR_PIN_CTRL
        && pin_en_q[0] && pin_sel_q[0] |=> !reg_rdata_out[PIN_LEVEL_LO])
        else $error("level bit visible in interrupt mode");
    a_store_locked: assert property (store_buf0_out |-> !$past(flag_q[0]))
        else $error("first buffer loaded while full");
    a_flag_after_store: assert property (store_buf1_out
        |-> flag_q[1] ##1 rx_loaded_flag_out[1])
        else $error("loaded flag not set");
    a_rollover: assert property (msg_done_in && acc0 && flag_q[0]
        && roll_q && !flag_q[1] |=> store_buf1_out && hit1_q[2:1] == 2'h0)
        else $error("rollover failed");
    a_overflow0: assert property (msg_done_in && acc0 && flag_q[0] && !roll_q
        |=> ovr_q[0] && !store_buf0_out)
        else $error("overflow not flagged");
    a_status_code: assert property (store_buf1_out && !store_buf0_out
        |-> status_code_out == STATUS_BUF1)
        else $error("status code wrong");
    a_error_frame: assert property (msg_done_in && !msg_valid_in |=> error_frame_out)
        else $error("error frame missing");
    a_irq_load: assert property (flag_q[0] && rx_loaded_irq_enable_in[0] |=> !irq_b_out)
        else $error("interrupt not raised");
    a_irq_overflow: assert property (error_irq_enable_in && |ovr_q |=> !irq_b_out)
        else $error("overflow interrupt not raised");
    a_flag_set_wins: assert property (do_store0 |=> flag_q[0])
        else $error("loaded flag lost on a clear");

    c_store0: cover property (store_buf0_out);
    c_rolled: cover property (msg_done_in && rolled);
    c_sof: cover property (frame_start_out);
    c_any_error_load: cover property (msg_done_in && !msg_valid_in && do_store0);
endmodule
`default_nettype wire

// >>> can_line_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// bus line model: recessive high between frames
module can_line_model (
    input wire logic link_clk_in,
    output logic line_out
);
    initial line_out = 1'b1;
    // idle well past eleven bits first, so the detector is armed
    task automatic frame_start(input int dom_ticks);
        repeat (120) @(posedge link_clk_in);
        #1;
        line_out = 1'b0;
        repeat (dom_ticks) @(posedge link_clk_in);
        #1;
        line_out = 1'b1;
        repeat (30) @(posedge link_clk_in);
    endtask
endmodule
`default_nettype wire

// >>> can_rx_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module can_rx_control_tb;
    import can_rx_pkg::*;
    logic clock_in, rst_b_in, link_clk_in, line, wr, rd, sof_en, done, valid, rtr, m0, f0, m1;
    logic err_ie, fs, as, st0, st1, ef, irq_b;
    logic [7:0] addr, wdata, wmask, rdata;
    logic [2:0] f1, st;
    logic [1:0] flag_clr, ovr_clr, rx_ie, flag, ovr, dbf, pin, pin_oe;
    logic [3:0] status;
    int bad_count, cmp_count, fs_cnt, as_cnt;
    can_line_model line_m (.link_clk_in(link_clk_in), .line_out(line));
    can_rx_control uut (.clock_in(clock_in), .rst_b_in(rst_b_in), .link_clk_in(link_clk_in),
        .bus_receive_line_in(line), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wmask_in(wmask), .reg_rdata_out(rdata),
        .sof_enable_in(sof_en), .frame_start_out(fs), .assemble_start_out(as),
        .msg_done_in(done), .msg_valid_in(valid), .msg_rtr_in(rtr), .buf0_match_in(m0),
        .buf0_filter_in(f0), .buf1_match_in(m1), .buf1_filter_in(f1),
        .store_buf0_out(st0), .store_buf1_out(st1), .error_frame_out(ef),
        .rx_flag_clear_in(flag_clr), .overflow_clear_in(ovr_clr),
        .rx_loaded_irq_enable_in(rx_ie), .error_irq_enable_in(err_ie),
        .rx_loaded_flag_out(flag), .overflow_flag_out(ovr), .status_code_out(status),
        .irq_b_out(irq_b), .data_byte_filter_out(dbf), .buf_full_pin_out(pin),
        .buf_full_pin_oe_out(pin_oe));
    // ==========================================================
    // clocks, pulse counters
    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end
    initial begin
        link_clk_in = 1'b0;
        #7;
        forever #15 link_clk_in = ~link_clk_in;
    end
    // sampled mid-cycle, away from the edge that launches the pulses
    always @(negedge clock_in) begin
        if (fs === 1'b1) fs_cnt++;
        if (as === 1'b1) as_cnt++;
    end
    // ==========================================================
    // tasks
    task automatic close_out();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
        cyc(1);
        wr = 1'b1;
        addr = a;
        wdata = d;
        wmask = m;
        cyc(1);
        wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        cyc(1);
        rd = 1'b1;
        addr = a;
        cyc(1);
        rd = 1'b0;
        cyc(1);
        chk(rdata, exp);
    endtask
    // st holds {store second, store first, error frame} in the cycle after the request
    task automatic msg(input logic v, r, a0, h0, a1, input logic [2:0] h1);
        cyc(1);
        done = 1'b1;
        valid = v;
        rtr = r;
        m0 = a0;
        f0 = h0;
        m1 = a1;
        f1 = h1;
        cyc(1);
        done = 1'b0;
        st = {st1, st0, ef};
        cyc(2);
    endtask
    task automatic clr(input logic [1:0] f, input logic [1:0] o);
        cyc(1);
        flag_clr = f;
        ovr_clr = o;
        cyc(1);
        flag_clr = 2'h0;
        ovr_clr = 2'h0;
        cyc(3);
    endtask
    // ==========================================================
    // watchdog: whole sequence needs well under 60 us
    initial begin
        #200000;
        bad_count++;
        $display("MISMATCH at %0t: timeout", $time);
        close_out();
    end
    initial begin
        {rst_b_in, wr, rd, sof_en, done, valid, rtr, m0, f0, m1, err_ie} = 11'h000;
        {addr, wdata, wmask, f1, flag_clr, ovr_clr} = 31'h0;
        rx_ie = 2'h3;
        fs_cnt = 0;
        as_cnt = 0;
        repeat (5) @(posedge clock_in);
        #1;
        rst_b_in = 1'b1;
        err_ie = 1'b1;
        rd_chk(ADDR_PIN_CTRL, REG_RESET);
        rd_chk(ADDR_BUF0_CTRL, REG_RESET);
        rd_chk(ADDR_BUF1_CTRL, REG_RESET);
        rd_chk(8'h33, 8'h00);
        chk(8'(dbf), 8'h03);
        chk(8'(pin_oe), 8'h00);
        wr_reg(ADDR_PIN_CTRL, 8'h0c, 8'hff);
        cyc(2);
        chk(8'({pin_oe, pin}), 8'h0c);
        wr_reg(ADDR_PIN_CTRL, 8'h10, 8'h10);
        cyc(2);
        chk(8'({pin_oe, pin}), 8'h0d);
        rd_chk(ADDR_PIN_CTRL, 8'h1c);
        wr_reg(ADDR_PIN_CTRL, 8'h3f, 8'hff);
        rd_chk(ADDR_PIN_CTRL, 8'h0f);
        chk(8'({pin_oe, pin}), 8'h0f);
        msg(1, 1, 1, 1, 0, 3'h0);
        chk(8'(st), 8'h02);
        chk(8'(status), 8'(STATUS_BUF0));
        chk(8'({flag, pin, irq_b}), 8'h0c);
        rd_chk(ADDR_BUF0_CTRL, 8'h09);
        msg(1, 0, 1, 0, 0, 3'h0);
        chk(8'({st, ovr}), 8'h01);
        rd_chk(ADDR_BUF0_CTRL, 8'h09);
        wr_reg(ADDR_BUF0_CTRL, 8'h04, 8'h04);
        rd_chk(ADDR_BUF0_CTRL, 8'h0f);
        msg(1, 0, 1, 0, 0, 3'h0);
        chk(8'(st), 8'h04);
        chk(8'({status, flag}), 8'({STATUS_BUF1, 2'h3}));
        rd_chk(ADDR_BUF1_CTRL, 8'h00);
        rd_chk(ADDR_BUF0_CTRL, 8'h0e);
        rx_ie = 2'h0;
        msg(1, 0, 0, 0, 1, 3'h5);
        chk(8'({st, ovr}), 8'h03);
        chk(8'(irq_b), 8'h00);
        rx_ie = 2'h3;
        clr(2'h3, 2'h3);
        chk(8'({flag, ovr, pin, irq_b}), 8'h07);
        msg(1, 1, 0, 0, 1, 3'h5);
        chk(8'(st), 8'h04);
        rd_chk(ADDR_BUF1_CTRL, 8'h0d);
        msg(0, 0, 1, 0, 0, 3'h0);
        chk(8'({st, flag[0]}), 8'h02);
        wr_reg(ADDR_BUF0_CTRL, 8'h60, 8'h60);
        cyc(2);
        chk(8'(dbf), 8'h02);
        msg(0, 0, 0, 0, 0, 3'h0);
        chk(8'({st, flag[0]}), 8'h07);
        sof_en = 1'b1;
        line_m.frame_start(10);
        cyc(10);
        chk(8'(fs_cnt), 8'h01);
        line_m.frame_start(3);
        cyc(10);
        chk(8'({fs_cnt[3:0], as_cnt[3:0]}), 8'h11);
        sof_en = 1'b0;
        line_m.frame_start(10);
        cyc(10);
        chk(8'({fs_cnt[3:0], as_cnt[3:0]}), 8'h12);
        close_out();
    end
endmodule
`default_nettype wire
